// file: design/oat_pkg.sv
// Purpose: shared constants and types for the orientation angle threshold block
// Assumes: 14-bit two's complement samples at 2 g full scale, 1 g = 4096 counts
// Notes:   register indexes are word indexes; the byte address is four times the index
package oat_pkg;

    // ==================================================================
    // sample format
    localparam int unsigned ACC_W = 14;
    localparam logic [ACC_W-1:0] OVER_LIMIT = 14'h1400;   // 1.25 g

    // ==================================================================
    // register indexes
    localparam logic [7:0] IDX_STATUS     = 8'h10;
    localparam logic [7:0] IDX_CFG        = 8'h11;
    localparam logic [7:0] IDX_COUNT      = 8'h12;
    localparam logic [7:0] IDX_TILT       = 8'h13;
    localparam logic [7:0] IDX_TRIP       = 8'h14;
    localparam logic [7:0] IDX_CTRL       = 8'h20;
    localparam logic [7:0] IDX_INT_STATUS = 8'h21;
    localparam logic [7:0] IDX_INT_MASK   = 8'h22;

    // ==================================================================
    // reset values
    localparam logic [7:0] RST_CFG   = 8'h80;
    localparam logic [7:0] RST_COUNT = 8'h00;
    localparam logic [7:0] RST_TILT  = 8'h84;
    localparam logic [7:0] RST_TRIP  = 8'h1a;
    localparam logic [7:0] RST_CTRL  = 8'h00;
    localparam logic [1:0] RST_INT   = 2'h0;
    localparam logic [7:0] CTRL_MASK = 8'h0f;

    // ==================================================================
    // field positions
    localparam int CFG_DBMODE_BIT  = 7;
    localparam int CFG_ENABLE_BIT  = 6;
    localparam int TILT_BF_LSB     = 6;
    localparam int TILT_ZL_LSB     = 0;
    localparam int TRIP_TH_LSB     = 3;
    localparam int TRIP_HY_LSB     = 0;
    localparam int CTRL_ACTIVE_BIT = 0;
    localparam int CTRL_RATE_LSB   = 1;
    localparam int INT_CHANGE_BIT  = 0;
    localparam int INT_LOCK_BIT    = 1;

    // ==================================================================
    // angle tables, scaled so that 1 g = 4096
    // g * cos(trip angle) for back/front codes 0..3 (80, 75, 70, 65 deg)
    localparam logic [11:0] BF_COS [4] = '{12'h2c7, 12'h424, 12'h579, 12'h6c3};
    // g * sin(lockout angle), ideal-position column, codes 0..7
    localparam logic [11:0] LOCK_SIN [8] = '{12'h402, 12'h4ff, 12'h5fe, 12'h6fd,
                                             12'h800, 12'h8fe, 12'ha01, 12'hafe};
    // hysteresis half-width in degrees around the trip angle
    localparam logic [7:0] HYS_OFF [8] = '{8'h00, 8'h04, 8'h07, 8'h0b,
                                           8'h0e, 8'h11, 8'h15, 8'h18};
    localparam logic [7:0]  ANGLE_MIN   = 8'h01;
    localparam logic [7:0]  ANGLE_MAX   = 8'h59;
    localparam logic [7:0]  DEG_RIGHT   = 8'h5a;
    localparam logic [15:0] DEG_HALF    = 16'h00b4;
    localparam logic [17:0] BHASKARA_K  = 18'h09e34;

    // ==================================================================
    // orientation codes 00..11 in declaration order
    typedef enum logic [1:0] {
        UPRIGHT_NORMAL,
        UPRIGHT_INVERTED,
        SIDEWAYS_RIGHT,
        SIDEWAYS_LEFT
    } oat_orient_t;

    function automatic logic [ACC_W-1:0] absMag(input logic [ACC_W-1:0] v);
        return v[ACC_W-1] ? ACC_W'(-v) : v;
    endfunction

endpackage

// file: design/oat_angle_classifier.sv
// Purpose: per-sample angle comparison giving candidate orientation, back/front, lockout
// Assumes: inputs stable during the evaluating cycle; purely combinational
// Notes:   trigonometry uses a rational sine approximation, multipliers only
`timescale 1ns/1ps
module oat_angle_classifier
    import oat_pkg::*;
(
    input  wire logic [ACC_W-1:0] accelX,
    input  wire logic [ACC_W-1:0] accelY,
    input  wire logic [ACC_W-1:0] accelZ,
    input  wire logic [1:0]       backFrontCode,
    input  wire logic [2:0]       zLockCode,
    input  wire logic [4:0]       tripCode,
    input  wire logic [2:0]       hysCode,
    input  wire oat_orient_t      curOrient,
    input  wire logic             curBack,
    output oat_orient_t           candOrient,
    output logic                  candBack,
    output logic                  candLock
);

    // ==================================================================
    // lookups
    // unlisted codes fall to the nearest listed code below, or 15 deg
    function automatic logic [7:0] tripAngle(input logic [4:0] c);
        if (c < 5'h09)       return 8'h0f;
        else if (c < 5'h0c)  return 8'h14;
        else if (c < 5'h0d)  return 8'h1e;
        else if (c < 5'h0f)  return 8'h23;
        else if (c < 5'h10)  return 8'h28;
        else if (c < 5'h13)  return 8'h2d;
        else if (c < 5'h14)  return 8'h37;
        else if (c < 5'h17)  return 8'h3c;
        else if (c < 5'h19)  return 8'h46;
        else                 return 8'h4b;
    endfunction

    // true when atan(ay/ax) lies below angle a, via sin/cos cross products
    function automatic logic angleBelow(input logic [ACC_W-1:0] ay,
                                        input logic [ACC_W-1:0] ax,
                                        input logic [7:0]       a);
        logic [15:0] a16;
        logic [15:0] b16;
        logic [15:0] ps;
        logic [15:0] pc;
        logic [47:0] ns;
        logic [47:0] nc;
        logic [47:0] ds;
        logic [47:0] dc;
        logic [47:0] lhs;
        logic [47:0] rhs;
        a16 = {8'h00, a};
        b16 = {8'h00, DEG_RIGHT - a};
        ps  = a16 * (DEG_HALF - a16);
        pc  = b16 * (DEG_HALF - b16);
        ns  = {30'h0, ps, 2'h0};
        nc  = {30'h0, pc, 2'h0};
        ds  = {30'h0, BHASKARA_K - {2'h0, ps}};
        dc  = {30'h0, BHASKARA_K - {2'h0, pc}};
        lhs = {34'h0, ay} * nc * ds;
        rhs = {34'h0, ax} * ns * dc;
        return lhs < rhs;
    endfunction

    // ==================================================================
    // classification
    logic [ACC_W-1:0] ax;
    logic [ACC_W-1:0] ay;
    logic [ACC_W-1:0] az;
    logic [7:0]       base;
    logic [7:0]       off;
    logic [7:0]       toSideways;
    logic [7:0]       toUpright;
    logic [28:0]      rad2;
    logic [28:0]      lim2;
    logic             sideways;

    always_comb begin
        ax   = absMag(accelX);
        ay   = absMag(accelY);
        az   = absMag(accelZ);
        base = tripAngle(tripCode);
        off  = HYS_OFF[hysCode];
        toSideways = (base > off + ANGLE_MIN) ? base - off : ANGLE_MIN;
        toUpright  = (base + off > ANGLE_MAX) ? ANGLE_MAX : base + off;
        // back/front with a dead band that keeps the previous face
        if (!accelZ[ACC_W-1] && az > {2'h0, BF_COS[backFrontCode]}) begin
            candBack = 1'h0;
        end else if (accelZ[ACC_W-1] && az > {2'h0, BF_COS[backFrontCode]}) begin
            candBack = 1'h1;
        end else begin
            candBack = curBack;
        end
        // lockout when the in-plane component is below g*sin(lock angle)
        rad2 = 29'({15'h0, ax} * {15'h0, ax}) + 29'({15'h0, ay} * {15'h0, ay});
        lim2 = 29'({17'h0, LOCK_SIN[zLockCode]} * {17'h0, LOCK_SIN[zLockCode]});
        candLock = rad2 < lim2;
        // angle from the x axis; hysteresis picks the threshold by current mode
        sideways = angleBelow(ay, ax, curOrient[1] ? toUpright : toSideways);
        if (sideways) begin
            candOrient = accelX[ACC_W-1] ? SIDEWAYS_LEFT : SIDEWAYS_RIGHT;
        end else begin
            candOrient = accelY[ACC_W-1] ? UPRIGHT_NORMAL : UPRIGHT_INVERTED;
        end
        // a locked-out device keeps its last face and orientation
        if (candLock) begin
            candOrient = curOrient;
            candBack   = curBack;
        end
    end

endmodule

// file: design/oat_orientation_thresholds.sv
// Purpose: orientation angle thresholds, detection state and AHB-Lite register slave
// Assumes: samples arrive on clk as one-cycle sampleValid strobes; 2 g full scale
// Notes:   zero wait-state slave, always OKAY; unmapped reads return zero
//
// What this block does
// - two-bit back/front trip angle, default 70 deg
// - back/front decided from Z tilt per code
// - three-bit Z lockout field, default code 4
// - lockout codes map to rising lockout angles
// - five-bit trip threshold plus three-bit hysteresis
// - trip threshold codes map to listed angles
// - hysteresis splits trip into two angles
// - ideal orientations from signs of X and Y
// - change flag sets on change, read clears
// - freeze result when any axis exceeds 1.25 g
// - status packs orientation, back/front, lockout bits
// - rate or mode change resets debounce counter
`timescale 1ns/1ps
module oat_orientation_thresholds
    import oat_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             hsel,
    input  wire logic [31:0]      haddr,
    input  wire logic [1:0]       htrans,
    input  wire logic             hwrite,
    input  wire logic [2:0]       hsize,
    input  wire logic [31:0]      hwdata,
    input  wire logic             hready,
    output logic                  hreadyout,
    output logic                  hresp,
    output logic [31:0]           hrdata,
    input  wire logic             sampleValid,
    input  wire logic [ACC_W-1:0] accelX,
    input  wire logic [ACC_W-1:0] accelY,
    input  wire logic [ACC_W-1:0] accelZ,
    output logic                  irq
);

    // ==================================================================
    // bus front end
    logic        dpValid;
    logic        dpWrite;
    logic [7:0]  dpIndex;
    logic        addrPhase;
    logic        addrOk;
    logic [7:0]  addrIndex;
    logic [7:0]  readByte;
    logic        statusRead;

    assign addrPhase  = hsel && htrans[1] && hready;
    assign addrOk     = (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'h0)
                        && (hsize == 3'h2);
    assign addrIndex  = haddr[9:2];
    assign statusRead = addrPhase && !hwrite && addrOk && (addrIndex == IDX_STATUS);
    assign hreadyout  = 1'h1;
    assign hresp      = 1'h0;

    function automatic logic wrHit(input logic [7:0] idx);
        return dpValid && dpWrite && (dpIndex == idx);
    endfunction

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dpValid <= 1'h0;
            dpWrite <= 1'h0;
            dpIndex <= 8'h00;
        end else if (hready) begin
            dpValid <= addrPhase && addrOk;
            dpWrite <= hwrite;
            dpIndex <= addrIndex;
        end
    end

    // ==================================================================
    // configuration registers
    logic [7:0] cfgReg;
    logic [7:0] countReg;
    logic [7:0] tiltReg;
    logic [7:0] tripReg;
    logic [7:0] ctrlReg;
    logic [1:0] intMask;
    logic       tiltWrite;
    logic       tripWrite;
    logic       ctrlWrite;

    assign tiltWrite = wrHit(IDX_TILT);
    assign tripWrite = wrHit(IDX_TRIP);
    assign ctrlWrite = wrHit(IDX_CTRL);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cfgReg   <= RST_CFG;
            countReg <= RST_COUNT;
        end else begin
            if (wrHit(IDX_CFG)) begin
                cfgReg <= hwdata[7:0];
            end
            if (wrHit(IDX_COUNT)) begin
                countReg <= hwdata[7:0];
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tiltReg <= RST_TILT;
            tripReg <= RST_TRIP;
        end else begin
            if (tiltWrite) begin
                tiltReg <= hwdata[7:0];
            end
            if (tripWrite) begin
                tripReg <= hwdata[7:0];
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrlReg <= RST_CTRL;
            intMask <= RST_INT;
        end else begin
            if (ctrlWrite) begin
                ctrlReg <= hwdata[7:0] & CTRL_MASK;
            end
            if (wrHit(IDX_INT_MASK)) begin
                intMask <= hwdata[1:0];
            end
        end
    end

    // ==================================================================
    // field views
    logic       debMode;
    logic       plEnable;
    logic       active;
    logic [2:0] rateSel;
    logic       activeChange;
    logic       activeRise;
    logic       rateChange;

    assign debMode      = cfgReg[CFG_DBMODE_BIT];
    assign plEnable     = cfgReg[CFG_ENABLE_BIT];
    assign active       = ctrlReg[CTRL_ACTIVE_BIT];
    assign rateSel      = ctrlReg[CTRL_RATE_LSB +: 3];
    assign activeChange = ctrlWrite && (hwdata[CTRL_ACTIVE_BIT] != active);
    assign activeRise   = activeChange && hwdata[CTRL_ACTIVE_BIT];
    assign rateChange   = ctrlWrite && (hwdata[CTRL_RATE_LSB +: 3] != rateSel);

    // ==================================================================
    // angle comparison
    oat_orient_t orient;
    oat_orient_t candOrient;
    logic        backFront;
    logic        lockout;
    logic        candBack;
    logic        candLock;

    oat_angle_classifier u_classifier (
        .accelX        (accelX),
        .accelY        (accelY),
        .accelZ        (accelZ),
        .backFrontCode (tiltReg[TILT_BF_LSB +: 2]),
        .zLockCode     (tiltReg[TILT_ZL_LSB +: 3]),
        .tripCode      (tripReg[TRIP_TH_LSB +: 5]),
        .hysCode       (tripReg[TRIP_HY_LSB +: 3]),
        .curOrient     (orient),
        .curBack       (backFront),
        .candOrient    (candOrient),
        .candBack      (candBack),
        .candLock      (candLock)
    );

    // ==================================================================
    // detection and debounce
    logic       evalNow;
    logic       overRange;
    logic       candDiff;
    logic       commit;
    logic       changeEvent;
    logic       firstPending;
    logic       newChange;
    logic [7:0] debCount;

    assign evalNow   = sampleValid && active && plEnable;
    assign overRange = (absMag(accelX) > OVER_LIMIT) || (absMag(accelY) > OVER_LIMIT)
                       || (absMag(accelZ) > OVER_LIMIT);
    assign candDiff  = {candLock, candOrient, candBack} != {lockout, orient, backFront};
    // the first detection after activation skips the debounce so software sees a result
    assign commit      = evalNow && !overRange
                         && (firstPending || (candDiff && (debCount >= countReg)));
    assign changeEvent = commit;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            debCount <= 8'h00;
        end else if (rateChange || activeChange) begin
            debCount <= 8'h00;
        end else if (evalNow && !overRange) begin
            if (commit) begin
                debCount <= 8'h00;
            end else if (candDiff) begin
                debCount <= debCount + 8'h01;
            end else if (debMode) begin
                debCount <= 8'h00;
            end else if (debCount != 8'h00) begin
                debCount <= debCount - 8'h01;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            orient    <= UPRIGHT_NORMAL;
            backFront <= 1'h0;
            lockout   <= 1'h0;
        end else if (commit) begin
            orient    <= candOrient;
            backFront <= candBack;
            lockout   <= candLock;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            firstPending <= 1'h0;
        end else if (activeRise) begin
            firstPending <= 1'h1;
        end else if (commit) begin
            firstPending <= 1'h0;
        end
    end

    // a change in the read cycle wins, so no event is lost
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            newChange <= 1'h0;
        end else if (changeEvent) begin
            newChange <= 1'h1;
        end else if (statusRead) begin
            newChange <= 1'h0;
        end
    end

    // ==================================================================
    // interrupts
    logic [1:0] intStatus;
    logic [1:0] next_intStatus;
    logic [1:0] intSet;
    logic [1:0] intClr;

    always_comb begin
        intSet                 = 2'h0;
        intSet[INT_CHANGE_BIT] = changeEvent;
        intSet[INT_LOCK_BIT]   = commit && candLock && !lockout;
        intClr                 = wrHit(IDX_INT_STATUS) ? hwdata[1:0] : 2'h0;
        next_intStatus         = (intStatus & ~intClr) | intSet;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            intStatus <= RST_INT;
        end else begin
            intStatus <= next_intStatus;
        end
    end

    assign irq = |(intStatus & intMask);

    // ==================================================================
    // read path
    always_comb begin
        readByte = 8'h00;
        if (!addrOk) begin
            readByte = 8'h00;
        end else if (addrIndex == IDX_STATUS) begin
            readByte = {newChange, lockout, 3'h0, orient, backFront};
        end else if (addrIndex == IDX_CFG) begin
            readByte = cfgReg;
        end else if (addrIndex == IDX_COUNT) begin
            readByte = countReg;
        end else if (addrIndex == IDX_TILT) begin
            readByte = tiltReg;
        end else if (addrIndex == IDX_TRIP) begin
            readByte = tripReg;
        end else if (addrIndex == IDX_CTRL) begin
            readByte = ctrlReg;
        end else if (addrIndex == IDX_INT_STATUS) begin
            readByte = {6'h00, intStatus};
        end else if (addrIndex == IDX_INT_MASK) begin
            readByte = {6'h00, intMask};
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hrdata <= 32'h00000000;
        end else if (addrPhase && !hwrite) begin
            hrdata <= {24'h000000, readByte};
        end
    end

    // ==================================================================
    // checks
    sequence s_quietRead;
        statusRead && !changeEvent;
    endsequence

    sequence s_anyChange;
        changeEvent;
    endsequence

    property p_newClear;
        @(posedge clk) disable iff (rst)
        s_quietRead |=> !newChange;
    endproperty
    a_newClear: assert property (p_newClear)
        else $error("status read left the change flag set");

    property p_newSet;
        @(posedge clk) disable iff (rst)
        s_anyChange |=> newChange && intStatus[INT_CHANGE_BIT];
    endproperty
    a_newSet: assert property (p_newSet)
        else $error("change did not set the change flag");

    property p_freeze;
        @(posedge clk) disable iff (rst)
        (sampleValid && overRange) |=> $stable(orient) && $stable(backFront)
                                        && $stable(lockout);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("orientation moved during over-range sample");

    property p_debClear;
        @(posedge clk) disable iff (rst)
        (rateChange || activeChange) |=> (debCount == 8'h00);
    endproperty
    a_debClear: assert property (p_debClear)
        else $error("debounce counter survived rate or mode change");

    property p_gate;
        @(posedge clk) disable iff (rst)
        !evalNow |=> $stable(orient) && $stable(lockout) && $stable(backFront);
    endproperty
    a_gate: assert property (p_gate)
        else $error("orientation changed without an enabled sample");

    property p_statusPack;
        @(posedge clk) disable iff (rst)
        statusRead |=> hrdata == {24'h000000, $past(newChange), $past(lockout), 3'h0,
                                  $past(orient), $past(backFront)};
    endproperty
    a_statusPack: assert property (p_statusPack)
        else $error("status read data wrong");

    property p_tiltWrite;
        @(posedge clk) disable iff (rst)
        tiltWrite |=> tiltReg == $past(hwdata[7:0]);
    endproperty
    a_tiltWrite: assert property (p_tiltWrite)
        else $error("tilt register write lost");

    property p_tripWrite;
        @(posedge clk) disable iff (rst)
        tripWrite |=> tripReg == $past(hwdata[7:0]);
    endproperty
    a_tripWrite: assert property (p_tripWrite)
        else $error("trip register write lost");

    property p_lockCommit;
        @(posedge clk) disable iff (rst)
        (commit && candLock) |=> lockout && $stable(orient);
    endproperty
    a_lockCommit: assert property (p_lockCommit)
        else $error("lockout not taken or orientation moved");

    property p_irq;
        @(posedge clk) disable iff (rst)
        (intSet[INT_CHANGE_BIT] && intMask[INT_CHANGE_BIT]) |=> irq;
    endproperty
    a_irq: assert property (p_irq)
        else $error("unmasked change did not raise irq");

endmodule

// file: verif/tb.sv
// Purpose: self-checking bench for the orientation angle threshold block
// Assumes: zero wait-state AHB-Lite slave; byte address is four times the index
// Notes:   samples are 1 g = 14'h1000; debounce count zero until t_debounce sets it to one
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin errors++; \
    $display("FAIL t=%0t got=%h exp=%h", $time, a, e); end end
module tb
    import oat_pkg::*;
;
    logic             clk;
    logic             rst;
    logic             hsel;
    logic [31:0]      haddr;
    logic [1:0]       htrans;
    logic             hwrite;
    logic [2:0]       hsize;
    logic [31:0]      hwdata;
    logic             hreadyout;
    logic             hresp;
    logic [31:0]      hrdata;
    logic             sampleValid;
    logic [ACC_W-1:0] accelX;
    logic [ACC_W-1:0] accelY;
    logic [ACC_W-1:0] accelZ;
    logic             irq;
    logic [31:0]      rdVal;
    int               errors;
    int               comparisons;
    int               cycles;

    oat_orientation_thresholds i_oat_orientation_thresholds (
        .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .sampleValid(sampleValid), .accelX(accelX), .accelY(accelY),
        .accelZ(accelZ), .irq(irq));

    // ==================================================================
    // bus and sample drivers
    task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        hsize <= 3'h2;
        haddr <= {22'h0, idx, 2'h0};
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rdVal = hrdata;
    endtask

    task automatic sample(input logic [13:0] x, input logic [13:0] y, input logic [13:0] z);
        sampleValid <= 1'b1;
        accelX <= x;
        accelY <= y;
        accelZ <= z;
        @(posedge clk);
        sampleValid <= 1'b0;
        @(posedge clk);
    endtask

    // ==================================================================
    // scenarios
    task automatic t_regs();
        xfer(0, IDX_TILT, 0);
        `CHK(rdVal, 32'h84)
        xfer(0, IDX_TRIP, 0);
        `CHK(rdVal, 32'h1a)
        xfer(1, IDX_TILT, 32'hc7);
        xfer(0, IDX_TILT, 0);
        `CHK(rdVal, 32'hc7)
        xfer(1, IDX_TILT, 32'h84);
        xfer(0, 8'h30, 0);
        `CHK(rdVal, 32'h0)
        `CHK(hresp, 1'b0)
    endtask

    task automatic t_orient();
        xfer(1, IDX_CFG, 32'hc0);
        xfer(1, IDX_CTRL, 32'h01);
        sample(14'h0, 14'h3000, 14'h0);
        `CHK(irq, 1'b0)
        xfer(0, IDX_STATUS, 0);
        `CHK(rdVal, 32'h80)
        xfer(0, IDX_STATUS, 0);
        `CHK(rdVal, 32'h00)
        xfer(1, IDX_INT_MASK, 32'h1);
        // the write lands on the edge xfer returns at, so look one cycle later
        @(posedge clk);
        `CHK(irq, 1'b1)
        xfer(1, IDX_INT_STATUS, 32'h1);
        @(posedge clk);
        `CHK(irq, 1'b0)
        sample(14'h0, 14'h1000, 14'h3000);
        xfer(0, IDX_STATUS, 0);
        `CHK(rdVal, 32'h83)
        // over 1.25 g on x must leave the result untouched
        sample(14'h14cd, 14'h0, 14'h0);
        xfer(0, IDX_STATUS, 0);
        `CHK(rdVal, 32'h03)
        sample(14'h1000, 14'h0, 14'h0);
        xfer(0, IDX_STATUS, 0);
        `CHK(rdVal, 32'h85)
        sample(14'h0, 14'h0, 14'h1000);
        xfer(0, IDX_STATUS, 0);
        `CHK(rdVal, 32'hc5)
        xfer(0, IDX_INT_STATUS, 0);
        `CHK(rdVal, 32'h3)
    endtask

    // count of one needs two differing samples; a rate change restarts it
    task automatic t_debounce();
        xfer(1, IDX_COUNT, 32'h1);
        sample(14'h1000, 14'h0, 14'h0);
        xfer(1, IDX_CTRL, 32'h03);
        sample(14'h1000, 14'h0, 14'h0);
        xfer(0, IDX_STATUS, 0);
        `CHK(rdVal, 32'h45)
        sample(14'h1000, 14'h0, 14'h0);
        xfer(0, IDX_STATUS, 0);
        `CHK(rdVal, 32'h85)
        xfer(1, IDX_CFG, 32'h80);
        sample(14'h0, 14'h0, 14'h1000);
        xfer(0, IDX_STATUS, 0);
        `CHK(rdVal, 32'h05)
    endtask

    // ==================================================================
    // run control
    task automatic wrap_up();
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            wrap_up();
        end
    end

    initial begin
        {rst, hsel, haddr, htrans, hwrite, hsize, hwdata} = {1'b1, 71'h0};
        {sampleValid, accelX, accelY, accelZ} = 43'h0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_regs();
        t_orient();
        t_debounce();
        wrap_up();
    end
endmodule
